// [sler_pkg.sv]
// shared constants, kinds and carriers for the reservation manager
package sler_pkg;
  localparam logic [7:0]  SLER_OP_RESERVE    = 8'h16;
  localparam logic [7:0]  SLER_OP_FORMAT     = 8'h04;
  localparam logic [7:0]  SLER_ST_GOOD       = 8'h00;
  localparam logic [7:0]  SLER_ST_CHECK      = 8'h02;
  localparam logic [7:0]  SLER_ST_CONFLICT   = 8'h18;
  localparam logic [3:0]  SLER_SK_NONE       = 4'h0;
  localparam logic [3:0]  SLER_SK_ILLEGAL    = 4'h5;
  localparam logic [3:0]  SLER_SK_ATTENTION  = 4'h6;
  localparam int          SLER_MAX_EXTENTS   = 8;
  localparam int          SLER_INITIATORS    = 8;
  localparam int          SLER_BIT_ON_BEHALF = 4;
  localparam int          SLER_BIT_BENEF_HI  = 3;
  localparam int          SLER_BIT_BENEF_LO  = 1;
  localparam int          SLER_BIT_EXTENT    = 0;
  localparam int          SLER_DESC_SHIFT    = 3;
  localparam logic [31:0] SLER_CAPACITY_RST  = 32'h0000_5000;
  localparam logic [7:0]  SLER_ATTN_RST      = 8'hFF;
  localparam logic [3:0]  SLER_REG_CAPACITY  = 4'h0;
  localparam logic [3:0]  SLER_REG_STATUS    = 4'h4;
  localparam logic [3:0]  SLER_REG_ATTN      = 4'h8;

  typedef enum logic [1:0] {
    SLER_RS = 2'b00,
    SLER_WE = 2'b01,
    SLER_RE = 2'b10,
    SLER_EX = 2'b11
  } sler_kind_e;

  typedef enum logic [2:0] {
    SLER_IDLE    = 3'b000,
    SLER_EVAL    = 3'b001,
    SLER_COLLECT = 3'b011,
    SLER_CHECK   = 3'b010,
    SLER_COMMIT  = 3'b110
  } sler_state_e;

  typedef struct packed {
    logic [2:0]      initiator;
    logic [0:5][7:0] cdb;
    logic [31:0]     acc_lba;
    logic [23:0]     acc_cnt;
    logic            acc_rd;
    logic            acc_wr;
  } sler_cmd_s;

  typedef struct packed {
    logic [7:0] status;
    logic [3:0] sense;
    logic       perform;
  } sler_resp_s;

  typedef struct packed {
    logic        valid;
    logic [2:0]  owner;
    logic [2:0]  holder;
    logic [7:0]  resid;
    sler_kind_e  kind;
    logic [31:0] start;
    logic [23:0] cnt;
  } sler_entry_s;
endpackage : sler_pkg

// [sler_reservation_core.sv]
// reserve command decoder, reservation table and access arbitration
// What this block does
// - opcode 16 hex selects reserve handling
// - reserve request byte layout decoded
// - extent clear reserves whole unit
// - whole-unit reserve refused if others hold
// - same owner may re-reserve unit
// - unit reserve ignores identifier and length
// - unit held: other initiators get conflict
// - extents tagged with reservation identifier
// - zero list length changes nothing, good
// - too many extents: illegal request
// - more than free extents: conflict
// - start address beyond unit: illegal request
// - clashing overlaps inside request: illegal request
// - clean extent request is recorded
// - self-test or rst_b_in reset raises attention; bus device reset does not
// - clash with active reservation: conflict
// - extent descriptor eight bytes, high first
// - on-behalf flag reserves for named device
// - two kind bits select blocking type
// - zero block count runs to unit end
// - blocked access performs nothing, conflict
`timescale 1ns/1ps
module sler_reservation_core import sler_pkg::*; #(
  parameter int          MAX_EXTENTS      = SLER_MAX_EXTENTS,
  parameter logic [31:0] CAPACITY_DEFAULT = SLER_CAPACITY_RST
) (
  input  wire logic            clock_in,
  input  wire logic            rst_b_in,
  input  wire logic            cmd_valid_in,
  input  wire sler_cmd_s       cmd_in,
  output logic                 cmd_ready_out,
  input  wire logic            desc_valid_in,
  input  wire logic [0:7][7:0] desc_in,
  output logic                 desc_ready_out,
  output logic                 resp_valid_out,
  output sler_resp_s           resp_out,
  input  wire logic            bus_dev_reset_in,
  input  wire logic            self_test_in,
  input  wire logic [3:0]      avs_address_in,
  input  wire logic            avs_read_in,
  input  wire logic            avs_write_in,
  input  wire logic [31:0]     avs_writedata_in,
  input  wire logic [3:0]      avs_byteenable_in,
  output logic [31:0]          avs_readdata_out,
  output logic                 avs_waitrequest_out
);

  function automatic logic [32:0] range_end(input logic [31:0] s, input logic [23:0] c,
                                            input logic [31:0] cap);
    if (c == 24'h00_0000) return {1'b0, cap} - 33'h0_0000_0001;
    return {1'b0, s} + {9'h000, c} - 33'h0_0000_0001;
  endfunction : range_end

  function automatic logic overlaps(input logic [31:0] s1, input logic [32:0] e1,
                                    input logic [31:0] s2, input logic [32:0] e2);
    return ({1'b0, s1} <= e2) && ({1'b0, s2} <= e1);
  endfunction : overlaps

  // only RE/WE and RS/RS may overlap
  function automatic logic kinds_clash(input sler_kind_e a, input sler_kind_e b);
    return !(((a == SLER_RE) && (b == SLER_WE)) || ((a == SLER_WE) && (b == SLER_RE)) ||
             ((a == SLER_RS) && (b == SLER_RS)));
  endfunction : kinds_clash

  function automatic logic kind_blocks(input sler_kind_e k, input logic other,
                                       input logic rd, input logic wr);
    case (k)
      SLER_RE: return other && rd;
      SLER_WE: return other && wr;
      SLER_EX: return other && (rd || wr);
      SLER_RS: return wr;
      default: return 1'b0;
    endcase
  endfunction : kind_blocks

  sler_state_e state_q, next_state;
  sler_cmd_s   cur_q;
  sler_entry_s table_q [MAX_EXTENTS];
  sler_entry_s pend_q  [MAX_EXTENTS];
  logic [3:0]  cnt_q, next_cnt;
  logic [3:0]  idx_q, next_idx;
  logic        unit_held_q, next_unit_held;
  logic [2:0]  unit_owner_q, next_unit_owner;
  logic [2:0]  unit_holder_q, next_unit_holder;
  logic [7:0]  attn_q;
  logic [31:0] capacity_q;
  sler_resp_s  next_resp;
  logic        next_resp_valid;
  logic        wait_q;

  // request decode
  wire logic [2:0]  req_id           = cur_q.initiator;
  wire logic        is_reserve       = (cur_q.cdb[0] == SLER_OP_RESERVE);
  wire logic        is_format        = (cur_q.cdb[0] == SLER_OP_FORMAT);
  wire logic        extent_bit       = cur_q.cdb[1][SLER_BIT_EXTENT];
  wire logic        on_behalf_flag   = cur_q.cdb[1][SLER_BIT_ON_BEHALF];
  wire logic [2:0]  beneficiary_device_id = cur_q.cdb[1][SLER_BIT_BENEF_HI:SLER_BIT_BENEF_LO];
  wire logic [2:0]  new_holder       = on_behalf_flag ? beneficiary_device_id : req_id;
  wire logic [7:0]  resid            = cur_q.cdb[2];
  wire logic [15:0] list_len         = {cur_q.cdb[3], cur_q.cdb[4]};
  wire logic [12:0] n_ext            = list_len[15:SLER_DESC_SHIFT];
  wire logic        attn_hit         = attn_q[req_id];
  wire logic        unit_foreign     = unit_held_q && (unit_owner_q != req_id);
  wire logic        clear_all        = bus_dev_reset_in || self_test_in;
  wire logic        cmd_take         = cmd_valid_in && cmd_ready_out;
  wire logic        desc_take        = desc_valid_in && desc_ready_out;
  wire logic [32:0] acc_end          = range_end(cur_q.acc_lba, cur_q.acc_cnt, capacity_q);

  logic [MAX_EXTENTS-1:0] sup;
  logic [3:0]             free_cnt;
  logic                   foreign_ext, any_ext, access_block, table_clash, self_clash, bad_lba;
  logic [3:0]             first_free;

  always_comb begin
    sup          = '0;
    free_cnt     = 4'h0;
    foreign_ext  = 1'b0;
    any_ext      = 1'b0;
    access_block = 1'b0;
    table_clash  = 1'b0;
    self_clash   = 1'b0;
    bad_lba      = 1'b0;
    first_free   = 4'h0;
    for (int i = MAX_EXTENTS - 1; i >= 0; i--) begin
      // same owner and identifier: superseded
      sup[i] = table_q[i].valid && (table_q[i].owner == req_id) && (table_q[i].resid == resid);
      if (!table_q[i].valid || sup[i]) free_cnt = free_cnt + 4'h1;
      if (!table_q[i].valid) first_free = 4'(i);
      if (table_q[i].valid) any_ext = 1'b1;
      if (table_q[i].valid && (table_q[i].owner != req_id)) foreign_ext = 1'b1;
      if (table_q[i].valid &&
          overlaps(table_q[i].start, range_end(table_q[i].start, table_q[i].cnt, capacity_q),
                   cur_q.acc_lba, acc_end) &&
          kind_blocks(table_q[i].kind, table_q[i].holder != req_id, cur_q.acc_rd, cur_q.acc_wr))
        access_block = 1'b1;
    end
    for (int j = 0; j < MAX_EXTENTS; j++) begin
      if (4'(j) < cnt_q) begin
        if (pend_q[j].start >= capacity_q) bad_lba = 1'b1;
        for (int i = 0; i < MAX_EXTENTS; i++) begin
          if (table_q[i].valid && !sup[i] && kinds_clash(table_q[i].kind, pend_q[j].kind) &&
              overlaps(table_q[i].start, range_end(table_q[i].start, table_q[i].cnt, capacity_q),
                       pend_q[j].start, range_end(pend_q[j].start, pend_q[j].cnt, capacity_q)))
            table_clash = 1'b1;
          if ((i > j) && (4'(i) < cnt_q) && kinds_clash(pend_q[i].kind, pend_q[j].kind) &&
              overlaps(pend_q[i].start, range_end(pend_q[i].start, pend_q[i].cnt, capacity_q),
                       pend_q[j].start, range_end(pend_q[j].start, pend_q[j].cnt, capacity_q)))
            self_clash = 1'b1;
        end
      end
    end
  end

  wire logic chk_ok = (state_q == SLER_CHECK) && !bad_lba && !self_clash && !table_clash;

  // sequencing
  always_comb begin
    next_state       = state_q;
    next_cnt         = cnt_q;
    next_idx         = idx_q;
    next_unit_held   = unit_held_q;
    next_unit_owner  = unit_owner_q;
    next_unit_holder = unit_holder_q;
    next_resp_valid  = 1'b0;
    next_resp        = '{status: SLER_ST_GOOD, sense: SLER_SK_NONE, perform: 1'b0};
    case (state_q)
      SLER_IDLE: begin
        if (cmd_take) next_state = SLER_EVAL;
      end
      SLER_EVAL: begin
        next_state      = SLER_IDLE;
        next_resp_valid = 1'b1;
        next_cnt        = 4'h0;
        if (attn_hit) begin
          next_resp = '{status: SLER_ST_CHECK, sense: SLER_SK_ATTENTION, perform: 1'b0};
        end else if (is_reserve && !extent_bit) begin
          // identifier and length ignored
          if (unit_foreign || foreign_ext) begin
            next_resp.status = SLER_ST_CONFLICT;
          end else begin
            next_unit_held   = 1'b1;
            next_unit_owner  = req_id;
            next_unit_holder = new_holder;
          end
        end else if (is_reserve) begin
          if (unit_foreign)
            next_resp.status = SLER_ST_CONFLICT;
          else if (n_ext == 13'h0000)
            next_resp.status = SLER_ST_GOOD;
          else if (n_ext > 13'(MAX_EXTENTS))
            next_resp = '{status: SLER_ST_CHECK, sense: SLER_SK_ILLEGAL, perform: 1'b0};
          else if (n_ext > {9'h000, free_cnt})
            next_resp.status = SLER_ST_CONFLICT;
          else begin
            next_state      = SLER_COLLECT;
            next_resp_valid = 1'b0;
          end
        end else if ((unit_held_q && (unit_holder_q != req_id)) ||
                     (is_format && any_ext) || access_block) begin
          next_resp.status = SLER_ST_CONFLICT;
        end else begin
          next_resp.perform = 1'b1;
        end
      end
      SLER_COLLECT: begin
        if (desc_take) begin
          next_cnt = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == n_ext[3:0]) next_state = SLER_CHECK;
        end
      end
      SLER_CHECK: begin
        if (chk_ok) begin
          next_state = SLER_COMMIT;
          next_idx   = 4'h0;
          if (unit_held_q && (unit_owner_q == req_id)) next_unit_held = 1'b0;
        end else begin
          next_state      = SLER_IDLE;
          next_resp_valid = 1'b1;
          if (bad_lba || self_clash)
            next_resp = '{status: SLER_ST_CHECK, sense: SLER_SK_ILLEGAL, perform: 1'b0};
          else
            next_resp.status = SLER_ST_CONFLICT;
        end
      end
      SLER_COMMIT: begin
        next_idx = idx_q + 4'h1;
        if (idx_q + 4'h1 == cnt_q) begin
          next_state      = SLER_IDLE;
          next_resp_valid = 1'b1;
        end
      end
      default: next_state = SLER_IDLE;
    endcase
    if (clear_all) next_unit_held = 1'b0;
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q        <= SLER_IDLE;
      cnt_q          <= 4'h0;
      idx_q          <= 4'h0;
      unit_held_q    <= 1'b0;
      unit_owner_q   <= 3'h0;
      unit_holder_q  <= 3'h0;
      cmd_ready_out  <= 1'b0;
      desc_ready_out <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_out       <= '0;
    end else begin
      state_q        <= next_state;
      cnt_q          <= next_cnt;
      idx_q          <= next_idx;
      unit_held_q    <= next_unit_held;
      unit_owner_q   <= next_unit_owner;
      unit_holder_q  <= next_unit_holder;
      cmd_ready_out  <= (next_state == SLER_IDLE);
      desc_ready_out <= (next_state == SLER_COLLECT);
      resp_valid_out <= next_resp_valid;
      if (next_resp_valid) resp_out <= next_resp;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) cur_q <= '0;
    else if (cmd_take) cur_q <= cmd_in;
  end

  // hard reset owes every initiator an attention
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      attn_q <= SLER_ATTN_RST;
    end else if (self_test_in) begin
      attn_q <= SLER_ATTN_RST; // set beats the clear below
    end else if ((state_q == SLER_EVAL) && attn_hit) begin
      attn_q[req_id] <= 1'b0;
    end
  end

  // staged descriptors; owner kept for supersede
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int j = 0; j < MAX_EXTENTS; j++) pend_q[j] <= '0;
    end else if (desc_take) begin
      pend_q[cnt_q[2:0]] <= '{valid: 1'b1, owner: req_id, holder: new_holder, resid: resid,
                              kind: sler_kind_e'(desc_in[0][1:0]),
                              start: {desc_in[4], desc_in[5], desc_in[6], desc_in[7]},
                              cnt: {desc_in[1], desc_in[2], desc_in[3]}};
    end
  end

  // old state goes only once the new request is known to fit
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < MAX_EXTENTS; i++) table_q[i] <= '0;
    end else begin
      for (int i = 0; i < MAX_EXTENTS; i++) begin
        if (clear_all)
          table_q[i].valid <= 1'b0;
        else if (chk_ok && sup[i])
          table_q[i].valid <= 1'b0;
        else if ((state_q == SLER_COMMIT) && (first_free == 4'(i)))
          table_q[i] <= pend_q[idx_q[2:0]];
      end
    end
  end

  // register slave: one wait cycle, then the edge that completes
  wire logic       avs_req   = avs_read_in || avs_write_in;
  wire logic       avs_done  = avs_req && !wait_q;
  logic [3:0]      free_cnt_all;
  wire logic [3:0] used_cnt  = 4'(MAX_EXTENTS) - free_cnt_all;
  logic [31:0]     rd_mux;

  always_comb begin
    free_cnt_all = 4'h0;
    for (int i = 0; i < MAX_EXTENTS; i++)
      if (!table_q[i].valid) free_cnt_all = free_cnt_all + 4'h1;
  end

  assign rd_mux = (avs_address_in == SLER_REG_CAPACITY) ? capacity_q :
                  (avs_address_in == SLER_REG_STATUS)   ?
                    {9'h000, state_q, 4'h0, used_cnt, 1'b0, unit_holder_q, 1'b0, unit_owner_q, 3'h0, unit_held_q} :
                  (avs_address_in == SLER_REG_ATTN)     ? {24'h00_0000, attn_q} : 32'h0000_0000;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wait_q           <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      wait_q <= !(avs_req && wait_q);
      if (avs_read_in && wait_q) avs_readdata_out <= rd_mux;
    end
  end

  assign avs_waitrequest_out = wait_q;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      capacity_q <= CAPACITY_DEFAULT;
    end else if (avs_done && avs_write_in && (avs_address_in == SLER_REG_CAPACITY)) begin
      for (int b = 0; b < 4; b++)
        if (avs_byteenable_in[b]) capacity_q[8*b +: 8] <= avs_writedata_in[8*b +: 8];
    end
  end

endmodule : sler_reservation_core

// [sler_reservation_chk.sv]
// port assertions for the reservation manager
`timescale 1ns/1ps
module sler_reservation_chk import sler_pkg::*; #(
  parameter int MAX_EXTENTS = SLER_MAX_EXTENTS
) (
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  input wire logic       cmd_valid_in,
  input wire sler_cmd_s  cmd_in,
  input wire logic       cmd_ready_out,
  input wire logic       desc_valid_in,
  input wire logic       desc_ready_out,
  input wire logic       resp_valid_out,
  input wire sler_resp_s resp_out,
  input wire logic       self_test_in,
  input wire logic       avs_read_in,
  input wire logic       avs_waitrequest_out
);
  logic [7:0]  att_m;
  logic        att_t;
  logic [12:0] expn, dcnt;
  wire         take = cmd_valid_in && cmd_ready_out;
  wire [15:0]  len  = {cmd_in.cdb[3], cmd_in.cdb[4]};
  wire         ext  = cmd_in.cdb[0] == SLER_OP_RESERVE && cmd_in.cdb[1][SLER_BIT_EXTENT];
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      att_m <= 8'hFF;
      att_t <= 1'b0;
      expn  <= 13'h0;
      dcnt  <= 13'h0;
    end else begin
      att_m <= self_test_in ? 8'hFF : take ? att_m & ~(8'h01 << cmd_in.initiator) : att_m;
      if (take) att_t <= att_m[cmd_in.initiator];
      if (take) expn <= ext ? len[15:3] : 13'h0;
      dcnt <= take ? 13'h0 : dcnt + 13'(desc_valid_in && desc_ready_out);
    end
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_take;
    cmd_valid_in && cmd_ready_out;
  endsequence
  sequence s_early_verdict;
    ##1 !desc_ready_out ##1 resp_valid_out;
  endsequence
  a_plain_answer: assert property (s_take ##0 !ext |-> ##1 !resp_valid_out ##1 resp_valid_out)
    else $error("plain command answer late");
  a_zero_list: assert property (s_take ##0 (ext && len == 16'h0000) |-> s_early_verdict ##0
    (resp_out.status == SLER_ST_GOOD || resp_out.status == SLER_ST_CONFLICT || resp_out.sense == SLER_SK_ATTENTION))
    else $error("empty list not clean");
  a_too_many: assert property (s_take ##0 (ext && len[15:3] > MAX_EXTENTS) |-> s_early_verdict ##0
    (resp_out.status == SLER_ST_CONFLICT || resp_out.status == SLER_ST_CHECK && resp_out.sense != SLER_SK_NONE))
    else $error("oversized list accepted");
  a_attn_first: assert property (att_t && resp_valid_out |->
    resp_out.status == SLER_ST_CHECK && resp_out.sense == SLER_SK_ATTENTION)
    else $error("attention not reported");
  a_no_perform: assert property (resp_valid_out && resp_out.status != SLER_ST_GOOD |-> !resp_out.perform)
    else $error("refused command runs");
  a_check_sense: assert property (resp_valid_out && resp_out.status == SLER_ST_CHECK |->
    resp_out.sense == SLER_SK_ILLEGAL || resp_out.sense == SLER_SK_ATTENTION)
    else $error("bad check sense");
  a_desc_count: assert property (desc_valid_in && desc_ready_out |-> dcnt < expn)
    else $error("too many descriptors");
  a_busy_ready: assert property (resp_valid_out |-> cmd_ready_out && $past(!cmd_ready_out))
    else $error("ready not with answer");
  a_avs_answer: assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("register read late");
endmodule : sler_reservation_chk
bind sler_reservation_core sler_reservation_chk #(.MAX_EXTENTS(MAX_EXTENTS)) chk (.clock_in, .rst_b_in,
  .cmd_valid_in, .cmd_in, .cmd_ready_out, .desc_valid_in, .desc_ready_out, .resp_valid_out, .resp_out,
  .self_test_in, .avs_read_in, .avs_waitrequest_out);

// [sler_init_model.sv]
// initiator model: commands and descriptors
`timescale 1ns/1ps
module sler_init_model import sler_pkg::*; (
  input  wire logic       clock_in,
  input  wire logic       cmd_ready_in,
  input  wire logic       desc_ready_in,
  output logic            cmd_valid_out,
  output sler_cmd_s       cmd_out,
  output logic            desc_valid_out,
  output logic [0:7][7:0] desc_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    desc_valid_out = 1'b0;
    desc_out = '0;
  end
  // released lines invert so stale data cannot pass as fresh
  task automatic send(input sler_cmd_s c, input logic [63:0] d [8], input int n, input int gap);
    int k;
    cmd_out <= c;
    cmd_valid_out <= 1'b1;
    @(posedge clock_in);
    while (!cmd_ready_in) @(posedge clock_in);
    cmd_valid_out <= 1'b0;
    cmd_out <= ~c;
    for (k = 0; k < n; k++) begin
      repeat (gap) begin
        desc_valid_out <= 1'b0;
        desc_out <= ~desc_out;
        @(posedge clock_in);
      end
      desc_out <= d[k];
      desc_valid_out <= 1'b1;
      @(posedge clock_in);
      while (!desc_ready_in) @(posedge clock_in);
    end
    desc_valid_out <= 1'b0;
    desc_out <= ~desc_out;
  endtask : send
endmodule : sler_init_model

// [tb.sv]
// bench for the reservation manager
`timescale 1ns/1ps
module tb import sler_pkg::*; ;
  typedef struct {int o; int id; int s; int e; int k;} sler_tb_ent_s;
  logic            clock_in, rst_b_in, cmd_valid_in, cmd_ready_out, desc_valid_in, desc_ready_out, resp_valid_out;
  logic            bus_dev_reset_in, self_test_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [3:0]      avs_address_in, avs_byteenable_in;
  logic [31:0]     avs_writedata_in, avs_readdata_out, rd;
  logic [0:7][7:0] desc_in;
  sler_cmd_s       cmd_in;
  sler_resp_s      resp_out;
  logic [63:0]     dv [8];
  int              mismatches = 0, n_compared = 0, attn = 255, uh = -1, cap = 'h5000, k;
  int              dk [8], dc [8], ds [8];
  sler_tb_ent_s    tab [$];
  sler_reservation_core uut (.clock_in, .rst_b_in, .cmd_valid_in, .cmd_in, .cmd_ready_out, .desc_valid_in,
    .desc_in, .desc_ready_out, .resp_valid_out, .resp_out, .bus_dev_reset_in, .self_test_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out);
  sler_init_model ini (.clock_in, .cmd_ready_in(cmd_ready_out), .desc_ready_in(desc_ready_out),
    .cmd_valid_out(cmd_valid_in), .cmd_out(cmd_in), .desc_valid_out(desc_valid_in), .desc_out(desc_in));
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  function automatic int fe(int s, int c);
    return c == 0 ? cap - 1 : s + c - 1;
  endfunction : fe
  function automatic bit clash(int a, int b);
    return !(a * b == 2 || a + b == 0);
  endfunction : clash
  function automatic bit blk(int h, int r, int w, int s, int e);
    foreach (tab[j])
      if (tab[j].s <= e && s <= tab[j].e && (tab[j].k == 0 ? w : tab[j].o != h &&
          (tab[j].k == 3 || tab[j].k == 2 && r || tab[j].k == 1 && w))) return 1;
    return 0;
  endfunction : blk
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clock_in);
    while (avs_waitrequest_out) @(posedge clock_in);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clock_in);
  endtask : avs
  task automatic pulse(input bit st_n);
    if (st_n) self_test_in <= 1'b1;
    else bus_dev_reset_in <= 1'b1;
    @(posedge clock_in);
    self_test_in <= 1'b0;
    bus_dev_reset_in <= 1'b0;
    @(posedge clock_in);
    tab.delete();
    uh = -1;
    if (st_n) attn = 255;
  endtask : pulse
  task automatic run(input int i, op, b1 = 0, id = 0, len = 0, lba = 0, rdw = 1, gap = 0);
    sler_cmd_s c;
    int st = 0, sk = 0, pf = 0, n = 0, nc = 0, h = 0, q = 0, tc = 0, j, t, p;
    if (attn[i]) begin
      attn[i] = 0;
      st = SLER_ST_CHECK;
      sk = SLER_SK_ATTENTION;
    end else if (op != SLER_OP_RESERVE) begin
      if (uh >= 0 && uh != i || op == 4 && tab.size() > 0 ||
          blk(i, rdw[0], rdw[1], lba, lba + 7)) st = SLER_ST_CONFLICT;
      else pf = 1;
    end else if (!b1[0]) begin
      h = b1[4] ? b1[3:1] : i;
      if (uh >= 0 && uh != h) st = SLER_ST_CONFLICT;
      foreach (tab[m]) if (tab[m].o != h) st = SLER_ST_CONFLICT;
      if (st == 0) uh = h;
    end else begin
      n = len / 8;
      foreach (tab[m]) q += !(tab[m].o == i && tab[m].id == id);
      if (uh >= 0 && uh != i) st = SLER_ST_CONFLICT;
      else if (n > 8) begin
        st = SLER_ST_CHECK;
        sk = SLER_SK_ILLEGAL;
      end else if (n > 8 - q) st = SLER_ST_CONFLICT;
      else if (n > 0) begin
        nc = n;
        for (j = 0; j < n; j++) begin
          if (ds[j] >= cap) sk = SLER_SK_ILLEGAL;
          for (t = 0; t < j; t++)
            if (ds[j] <= fe(ds[t], dc[t]) && ds[t] <= fe(ds[j], dc[j]) && clash(dk[j], dk[t])) sk = SLER_SK_ILLEGAL;
          foreach (tab[m])
            if (!(tab[m].o == i && tab[m].id == id) && ds[j] <= tab[m].e && tab[m].s <= fe(ds[j], dc[j])
                && clash(dk[j], tab[m].k)) tc = 1;
        end
        if (sk != 0) st = SLER_ST_CHECK;
        else if (tc) st = SLER_ST_CONFLICT;
        else begin
          for (p = tab.size() - 1; p >= 0; p--) if (tab[p].o == i && tab[p].id == id) tab.delete(p);
          if (uh == i) uh = -1;
          for (j = 0; j < n; j++) tab.push_back('{i, id, ds[j], fe(ds[j], dc[j]), dk[j]});
        end
      end
    end
    c.initiator = i[2:0];
    c.cdb = {op[7:0], b1[7:0], id[7:0], len[15:8], len[7:0], 8'h00};
    c.acc_lba = lba;
    c.acc_cnt = 24'h000008;
    c.acc_rd = rdw[0];
    c.acc_wr = rdw[1];
    for (j = 0; j < 8; j++) dv[j] = {6'h00, dk[j][1:0], dc[j][23:0], ds[j]};
    ini.send(c, dv, nc, gap);
    t = 0;
    do begin
      @(negedge clock_in);
      t++;
    end while (resp_valid_out !== 1'b1 && t < 100);
    if (t >= 100) mismatches++;
    if (op == SLER_OP_RESERVE) chk({20'h0, resp_out.status, resp_out.sense}, {20'h0, st[7:0], sk[3:0]});
    else chk({19'h0, resp_out}, {19'h0, st[7:0], sk[3:0], pf[0]});
    @(posedge clock_in);
  endtask : run
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    {rst_b_in, bus_dev_reset_in, self_test_in, avs_read_in, avs_write_in} = 5'h00;
    {avs_address_in, avs_byteenable_in, avs_writedata_in} = 40'h0;
    void'($urandom(10857));
    repeat (5) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    avs(1'b0, SLER_REG_CAPACITY, 32'h0, 4'hF);
    chk(rd, SLER_CAPACITY_RST);
    avs(1'b0, SLER_REG_ATTN, 32'h0, 4'hF);
    chk(rd, 32'h000000FF);
    avs(1'b1, SLER_REG_CAPACITY, 32'hFFFFFF20, 4'h1);
    avs(1'b0, SLER_REG_CAPACITY, 32'h0, 4'hF);
    chk(rd, 32'h00005020);
    avs(1'b1, SLER_REG_CAPACITY, SLER_CAPACITY_RST, 4'hF);
    avs(1'b1, 4'hC, 32'h12345678, 4'hF);
    avs(1'b0, 4'hC, 32'h0, 4'hF);
    chk(rd, 32'h0);
    for (k = 0; k < 8; k++) run(k, 8'h08, 0, 0, 0, $urandom_range(32'h4FF0));
    $display("test attention done");
    run(1, SLER_OP_RESERVE, 0, 8'hAB, 16'h0123);
    run(2, 8'h08);
    run(2, SLER_OP_RESERVE);
    run(1, SLER_OP_RESERVE);
    run(2, SLER_OP_RESERVE, 1, 5, 0);
    pulse(1'b0);
    run(2, 8'h2A, 0, 0, 0, 0, 2);
    $display("test unit done");
    run(3, SLER_OP_RESERVE, 1, 7, 0);
    run(3, SLER_OP_RESERVE, 1, 7, 72);
    {dk[0], ds[0], dc[0], dk[1], ds[1], dc[1]} = {32'd3, 32'h10, 32'h10, 32'd3, 32'h100, 32'h0};
    run(3, SLER_OP_RESERVE, 1, 7, 16, 0, 1, 2);
    run(4, 8'h2A, 0, 0, 0, 32'h4F00, 2);
    run(4, 8'h08, 0, 0, 0, 32'h18);
    run(3, 8'h08, 0, 0, 0, 32'h18);
    for (k = 0; k < 3; k++) begin
      {dk[0], ds[0], dc[0]} = {k, 32'h20 + k * 32'h10, 32'h10};
      run(5, SLER_OP_RESERVE, 1, k, 8);
      run(6, 8'h08, 0, 0, 0, ds[0], 1);
      run(6, 8'h2A, 0, 0, 0, ds[0], 2);
    end
    run(6, SLER_OP_RESERVE, 1, 1, 32);
    {dk[0], ds[0], dc[0]} = {32'd3, 32'h5000, 32'h1};
    run(6, SLER_OP_RESERVE, 1, 1, 8);
    {ds[0], dc[0], ds[1], dc[1]} = {32'h3000, 32'h10, 32'h3004, 32'h4};
    run(6, SLER_OP_RESERVE, 1, 1, 16);
    ds[0] = 32'h18;
    run(6, SLER_OP_RESERVE, 1, 1, 8);
    {dk[0], ds[0]} = {32'd0, 32'h2000};
    run(3, SLER_OP_RESERVE, 1, 7, 8);
    run(4, 8'h08, 0, 0, 0, 32'h18);
    run(4, 8'h04);
    $display("test extents done");
    pulse(1'b0);
    run(5, SLER_OP_RESERVE, 8'h1C);
    run(6, 8'h08);
    run(5, 8'h08);
    pulse(1'b1);
    run(6, 8'h08);
    run(6, 8'h08);
    $display("test events done");
    finish_test;
  end
endmodule : tb
